//--- smbus_slave_pkg.sv
// constants and types shared by the byte-wide bus target
// assumes a single 10 MHz clock domain
package smbus_slave_pkg;

  // ==========================================================
  // addresses
  localparam logic [6:0] ADDR_BASE  = 7'h38;
  localparam logic [6:0] ALERT_ADDR = 7'h0C;
  localparam int         UPPER_BITS = 5;

  // ==========================================================
  // timing
  localparam int CLK_HZ         = 10000000;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

  // ==========================================================
  // byte framing and reset values
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // ==========================================================
  // protocol states
  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,
    ST_ADDR  = 11'h002,
    ST_AACK  = 11'h004,
    ST_INDEX = 11'h008,
    ST_IACK  = 11'h010,
    ST_WDATA = 11'h020,
    ST_WACK  = 11'h040,
    ST_WDONE = 11'h080,
    ST_RDATA = 11'h100,
    ST_MACK  = 11'h200,
    ST_SKIP  = 11'h400
  } state_type;

endpackage

//--- bus_event_if.sv
// bundle of synchronised line levels and bus events
// assumes producer and consumer share one clock
`timescale 1ns/1ps
`default_nettype none
interface bus_event_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic activity;
  modport sense (output scl, sda, scl_rise, scl_fall, start, stop, activity);
  modport fsm   (input  scl, sda, scl_rise, scl_fall, start, stop, activity);
endinterface
`default_nettype wire

//--- bus_sense.sv
// line synchroniser and start/stop/edge detector
// assumes scl and sda pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bus_sense (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   scl_pin,
  input  wire logic   sda_pin,
  bus_event_if.sense  ev
);

  // ==========================================================
  // two-stage sync plus one history stage
  logic [1:0] meta_q, meta_d;
  logic [1:0] sync_q, sync_d;
  logic [1:0] prev_q, prev_d;

  always_comb begin
    meta_d = {scl_pin, sda_pin};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // ==========================================================
  // events
  assign ev.scl      = sync_q[1];
  assign ev.sda      = sync_q[0];
  assign ev.scl_rise = sync_q[1] & ~prev_q[1];
  assign ev.scl_fall = ~sync_q[1] & prev_q[1];
  assign ev.start    = sync_q[1] & prev_q[1] & ~sync_q[0] & prev_q[0];
  assign ev.stop     = sync_q[1] & prev_q[1] & sync_q[0] & ~prev_q[0];
  assign ev.activity = |(sync_q ^ prev_q);

endmodule // bus_sense
`default_nettype wire

//--- smbus_byte_slave.sv
// byte-wide bus target: four single-byte protocols, pointer, timeout
// assumes open-drain lines resolved outside; register store outside
// What this block does
// - indexed read: write index, restart, read one
// - data only after complete ordered read sequence
// - send byte loads pointer, moves no data
// - receive byte returns byte at pointer
// - exactly one byte per pointer read
// - waits out clock held low by others
// - alert address answered only when enabled
// - 30 ms quiet bus returns to idle
// - write commits single byte on correct stop
// - address 0111000 or 0111001 by select pin
// - select latched on first upper-five match
// - other protocols refused as invalid
`timescale 1ns/1ps
`default_nettype none
module smbus_byte_slave #(
  parameter int TIMEOUT_CYCLES = smbus_slave_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE,
  input  wire logic       ADDR_SEL,
  input  wire logic       ALERT_RESPONSE_ENABLE,
  output var  logic [7:0] REG_INDEX,
  output var  logic [7:0] REG_WDATA,
  output var  logic       REG_WR_STROBE,
  output var  logic       REG_RD_STROBE,
  input  wire logic [7:0] REG_RD_DATA
);

  bus_event_if ev ();
  bus_sense u_sense (
    .clk     (CLK),
    .rst_n   (RST_N),
    .scl_pin (SCL_IN),
    .sda_pin (SDA_IN),
    .ev      (ev.sense)
  );

  // ==========================================================
  // pin sync of address select and enable
  logic [1:0] pin_m_q, pin_m_d;
  logic [1:0] pin_q, pin_d;
  always_comb begin
    pin_m_d = {ADDR_SEL, ALERT_RESPONSE_ENABLE};
    pin_d   = pin_m_q;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_m_q <= 2'h0;
      pin_q   <= 2'h0;
    end else begin
      pin_m_q <= pin_m_d;
      pin_q   <= pin_d;
    end
  end

  // ==========================================================
  // inactivity timeout
  logic [31:0] to_cnt_q, to_cnt_d;
  logic        to_hit;
  always_comb begin
    to_hit   = (to_cnt_q == 32'(TIMEOUT_CYCLES - 1));
    to_cnt_d = to_cnt_q + 32'h1;
    if (ev.activity || to_hit) begin
      to_cnt_d = 32'h0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      to_cnt_q <= 32'h0;
    end else begin
      to_cnt_q <= to_cnt_d;
    end
  end

  // ==========================================================
  // protocol engine
  smbus_slave_pkg::state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] wdata_q, wdata_d;
  logic       oe_q, oe_d;
  logic       wr_q, wr_d;
  logic       rd_q, rd_d;
  logic       lock_q, lock_d;
  logic       lock_sel_q, lock_sel_d;
  logic [6:0] own_addr;
  logic       upper_hit;
  logic       addr_hit;
  logic       byte_end;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    sr_d       = sr_q;
    idx_d      = idx_q;
    ptr_d      = ptr_q;
    wdata_d    = wdata_q;
    oe_d       = oe_q;
    wr_d       = 1'b0;
    rd_d       = 1'b0;
    lock_d     = lock_q;
    lock_sel_d = lock_sel_q;
    own_addr   = {smbus_slave_pkg::ADDR_BASE[6:1], lock_q ? lock_sel_q : pin_q[1]};
    upper_hit  = (sr_q[7:8-smbus_slave_pkg::UPPER_BITS] ==
                  smbus_slave_pkg::ADDR_BASE[6:7-smbus_slave_pkg::UPPER_BITS]);
    addr_hit   = (sr_q[7:1] == own_addr) ||
                 (pin_q[0] && sr_q[7:1] == smbus_slave_pkg::ALERT_ADDR);
    byte_end   = ev.scl_fall && (cnt_q == smbus_slave_pkg::BYTE_BITS);
    if (to_hit) begin
      state_d = smbus_slave_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else if (ev.stop) begin
      if (state_q == smbus_slave_pkg::ST_WDONE) begin
        ptr_d = idx_q;
        wr_d  = 1'b1;
      end else if (state_q == smbus_slave_pkg::ST_WDATA && cnt_q == 4'h1) begin // stop follows one clock rise
        ptr_d = idx_q;
      end
      state_d = smbus_slave_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else if (ev.start) begin
      if (state_q == smbus_slave_pkg::ST_WDATA && cnt_q == 4'h1) begin // restart follows one clock rise
        ptr_d = idx_q;
      end
      state_d = smbus_slave_pkg::ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else begin
      // only edges move the engine, so a held-low clock just waits
      unique case (state_q)
        smbus_slave_pkg::ST_IDLE, smbus_slave_pkg::ST_SKIP: begin
          oe_d = 1'b0;
        end
        smbus_slave_pkg::ST_ADDR, smbus_slave_pkg::ST_INDEX, smbus_slave_pkg::ST_WDATA: begin
          if (ev.scl_rise) begin
            sr_d  = {sr_q[6:0], ev.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_d = 4'h0;
            oe_d  = 1'b1;
            if (state_q == smbus_slave_pkg::ST_ADDR) begin
              if (upper_hit && !lock_q) begin
                lock_d     = 1'b1;
                lock_sel_d = pin_q[1];
              end
              if (addr_hit) begin
                state_d = smbus_slave_pkg::ST_AACK;
                rd_d    = sr_q[0];
              end else begin
                state_d = smbus_slave_pkg::ST_SKIP;
                oe_d    = 1'b0;
              end
            end else if (state_q == smbus_slave_pkg::ST_INDEX) begin
              idx_d   = sr_q;
              state_d = smbus_slave_pkg::ST_IACK;
            end else begin
              wdata_d = sr_q;
              state_d = smbus_slave_pkg::ST_WACK;
            end
          end
        end
        smbus_slave_pkg::ST_AACK: begin
          if (ev.scl_fall) begin
            if (sr_q[0]) begin
              sr_d    = REG_RD_DATA;
              oe_d    = ~REG_RD_DATA[7];
              state_d = smbus_slave_pkg::ST_RDATA;
            end else begin
              oe_d    = 1'b0;
              state_d = smbus_slave_pkg::ST_INDEX;
            end
          end
        end
        smbus_slave_pkg::ST_IACK: begin
          if (ev.scl_fall) begin
            oe_d    = 1'b0;
            state_d = smbus_slave_pkg::ST_WDATA;
          end
        end
        smbus_slave_pkg::ST_WACK: begin
          if (ev.scl_fall) begin
            oe_d    = 1'b0;
            state_d = smbus_slave_pkg::ST_WDONE;
          end
        end
        smbus_slave_pkg::ST_WDONE: begin
          if (ev.scl_fall) begin // a rise alone may still end in stop
            state_d = smbus_slave_pkg::ST_SKIP;
          end
        end
        smbus_slave_pkg::ST_RDATA: begin
          if (ev.scl_fall) begin
            if (cnt_q == smbus_slave_pkg::BYTE_BITS - 4'h1) begin
              oe_d    = 1'b0;
              state_d = smbus_slave_pkg::ST_MACK;
            end else begin
              sr_d  = {sr_q[6:0], 1'b0};
              oe_d  = ~sr_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        smbus_slave_pkg::ST_MACK: begin
          if (ev.scl_rise) begin
            state_d = smbus_slave_pkg::ST_SKIP;
          end
        end
        default: begin
          state_d = smbus_slave_pkg::ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q    <= smbus_slave_pkg::ST_IDLE;
      cnt_q      <= 4'h0;
      sr_q       <= smbus_slave_pkg::BYTE_RST;
      idx_q      <= smbus_slave_pkg::BYTE_RST;
      ptr_q      <= smbus_slave_pkg::BYTE_RST;
      wdata_q    <= smbus_slave_pkg::BYTE_RST;
      oe_q       <= 1'b0;
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      lock_q     <= 1'b0;
      lock_sel_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sr_q       <= sr_d;
      idx_q      <= idx_d;
      ptr_q      <= ptr_d;
      wdata_q    <= wdata_d;
      oe_q       <= oe_d;
      wr_q       <= wr_d;
      rd_q       <= rd_d;
      lock_q     <= lock_d;
      lock_sel_q <= lock_sel_d;
    end
  end
  assign SDA_OUT       = 1'b0;
  assign SDA_OE        = oe_q;
  assign REG_INDEX     = ptr_q;
  assign REG_WDATA     = wdata_q;
  assign REG_WR_STROBE = wr_q;
  assign REG_RD_STROBE = rd_q;
  // ==========================================================
  // checks
  sequence s_addr_done;
    state_q == smbus_slave_pkg::ST_ADDR && byte_end && !to_hit && !ev.stop && !ev.start;
  endsequence

  a_read_strobe_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    s_addr_done ##0 (addr_hit && sr_q[0]) |=> REG_RD_STROBE && SDA_OE)
    else $error("read header not strobed");
  a_foreign_addr_nack: assert property (@(posedge CLK) disable iff (!RST_N)
    s_addr_done ##0 !addr_hit |=> state_q == smbus_slave_pkg::ST_SKIP && !SDA_OE)
    else $error("foreign address acknowledged");
  a_alert_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    s_addr_done ##0 (sr_q[7:1] == smbus_slave_pkg::ALERT_ADDR && !pin_q[0]) |=> !SDA_OE)
    else $error("alert address answered while disabled");
  a_write_only_at_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_WR_STROBE |-> $past(state_q) == smbus_slave_pkg::ST_WDONE && REG_INDEX == $past(idx_q))
    else $error("write strobe without complete write");
  a_send_no_data: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == smbus_slave_pkg::ST_WDATA && cnt_q == 4'h1 && ev.stop && !to_hit)
    |=> !REG_WR_STROBE && REG_INDEX == $past(idx_q))
    else $error("send byte mishandled");
  a_one_byte_read: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == smbus_slave_pkg::ST_MACK && ev.scl_rise && !to_hit && !ev.start && !ev.stop)
    |=> state_q == smbus_slave_pkg::ST_SKIP ##1 !SDA_OE)
    else $error("second read byte offered");
  a_timeout_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    to_hit |=> state_q == smbus_slave_pkg::ST_IDLE && !SDA_OE)
    else $error("timeout did not idle the engine");
  a_lock_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    lock_q |=> lock_q && $stable(lock_sel_q))
    else $error("latched address select changed");
  a_hold_while_low: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == smbus_slave_pkg::ST_RDATA && !ev.scl_fall && !ev.start && !ev.stop && !to_hit)
    |=> $stable(sr_q) && $stable(SDA_OE))
    else $error("read data moved without clock edge");

endmodule // smbus_byte_slave
`default_nettype wire

//--- smbus_host_model.sv
// host master model driving the two bus lines
// assumes the bench resolves open-drain sda and feeds it back
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  int low_cyc = 8;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ==========================================================
  // bit level
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= ~b;
    wait_clk(low_cyc);
    scl <= 1'b1;
    wait_clk(6);
    s = sda;
    wait_clk(2);
  endtask

  // ==========================================================
  // conditions and bytes
  task automatic start();
    scl <= 1'b0;
    wait_clk(6);
    sda_low <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_low <= 1'b1;
    wait_clk(8);
  endtask

  task automatic stop();
    scl <= 1'b0;
    wait_clk(6);
    sda_low <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_low <= 1'b0;
    wait_clk(8);
  endtask

  // msb first, then the device ack bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // master ack or nack after the byte; the target ends the read after one byte either way
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, s);
  endtask
endmodule // smbus_host_model
`default_nettype wire

//--- tb_smbus_byte_slave.sv
// self-checking bench for the byte-wide bus target
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_byte_slave;
  localparam int TO = 200;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       addr_sel = 1'b0;
  logic       alert_response_enable = 1'b0;
  logic       scl;
  logic       host_low;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] reg_index;
  logic [7:0] reg_wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rd_data = 8'h00;
  int         failures = 0;
  int         n_compared = 0;
  int         n_wr = 0;
  int         n_rd = 0;
  int         n0;
  logic [31:0] seed;
  logic [7:0] idx;
  logic [7:0] dat;
  logic [7:0] got;
  logic [6:0] me;

  always #50 clk = ~clk;
  assign sda = ~(host_low | (sda_oe & ~sda_out));

  // ==========================================================
  // register store and strobe counters
  function automatic logic [7:0] reg_model(input logic [7:0] i);
    return {i[3:0], i[7:4]} ^ 8'h5A;
  endfunction

  always @(posedge clk) begin
    rd_data <= reg_model(reg_index);
    if (wr_stb === 1'b1) n_wr++;
    if (rd_stb === 1'b1) n_rd++;
  end

  smbus_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

  smbus_byte_slave #(.TIMEOUT_CYCLES(TO)) DUT (
    .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDR_SEL(addr_sel), .ALERT_RESPONSE_ENABLE(alert_response_enable), .REG_INDEX(reg_index),
    .REG_WDATA(reg_wdata), .REG_WR_STROBE(wr_stb), .REG_RD_STROBE(rd_stb), .REG_RD_DATA(rd_data));

  // ==========================================================
  // checks and transactions
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    h.wbyte(b, a);
    check(what, {7'h00, exp_ack}, {7'h00, a});
  endtask

  task automatic write_txn(input logic [7:0] i, input logic [7:0] d);
    n0 = n_wr;
    h.start();
    put({me, 1'b0}, 1'b1, "addr_w");
    put(i, 1'b1, "index");
    put(d, 1'b1, "data");
    h.stop();
    h.wait_clk(4);
    check("wr_count", 8'(n0 + 1), 8'(n_wr));
    check("wr_index", i, reg_index);
    check("wr_data", d, reg_wdata);
  endtask

  task automatic complete_run();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h8D32E2EE;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    addr_sel <= seed[0];
    me = {6'h1C, seed[0]};
    h.wait_clk(6);
    h.start();
    put({me ^ 7'h01, 1'b0}, 1'b0, "other_addr");
    h.stop();
    addr_sel <= ~addr_sel;
    write_txn(8'h00, 8'hFF);
    $display("done address select");
    for (int k = 0; k < 4; k++) begin
      idx = 8'($random(seed));
      dat = 8'($random(seed));
      write_txn(idx, dat);
      idx = 8'($random(seed));
      n0 = n_rd;
      h.start();
      put({me, 1'b0}, 1'b1, "addr_w");
      put(idx, 1'b1, "index");
      h.start();
      put({me, 1'b1}, 1'b1, "addr_r");
      h.rbyte(1'b0, got);
      h.stop();
      check("rd_data", reg_model(idx), got);
      check("rd_count", 8'(n0 + 1), 8'(n_rd));
    end
    $display("done random write and read");
    idx = 8'hFF;
    n0 = n_wr;
    h.start();
    put({me, 1'b0}, 1'b1, "addr_w");
    put(idx, 1'b1, "index");
    h.stop();
    h.wait_clk(4);
    check("send_index", idx, reg_index);
    check("send_no_wr", 8'(n0), 8'(n_wr));
    h.start();
    put({me, 1'b1}, 1'b1, "addr_r");
    h.rbyte(1'b1, got);
    check("recv_data", reg_model(idx), got);
    h.rbyte(1'b0, got);
    h.stop();
    check("recv_one_byte", 8'hFF, got);
    $display("done send and receive");
    for (int en = 0; en < 2; en++) begin
      alert_response_enable <= en[0];
      h.wait_clk(2);
      h.start();
      put({7'h0C, 1'b0}, en[0], "alert_addr");
      h.stop();
    end
    $display("done alert address");
    n0 = n_wr;
    h.start();
    put({me, 1'b0}, 1'b1, "addr_w");
    put(8'h12, 1'b1, "index");
    put(8'h34, 1'b1, "data");
    put(8'h56, 1'b0, "extra_data");
    h.stop();
    h.wait_clk(4);
    check("no_commit", 8'(n0), 8'(n_wr));
    h.low_cyc = 40;
    write_txn(8'hA5, 8'h3C);
    h.low_cyc = 8;
    $display("done invalid and stretch");
    h.start();
    put({me, 1'b1}, 1'b1, "addr_r");
    check("oe_before_quiet", 8'h01, {7'h00, sda_oe});
    h.wait_clk(TO + 60);
    check("oe_after_quiet", 8'h00, {7'h00, sda_oe});
    h.stop();
    write_txn(8'h01, 8'h80);
    $display("done timeout");
    complete_run();
  end
endmodule // tb_smbus_byte_slave
`default_nettype wire
